// [dtc_cfg.svh]
// dtc_cfg.svh - constants of the dual timer and external interrupt block
// assumes: included by bare name from the package and the testbench
`ifndef DTC_CFG_SVH
`define DTC_CFG_SVH

// ----------------------------------------------------------------------
// special function register addresses
// ----------------------------------------------------------------------
`define DTC_ADDR_FLAGS     8'h88
`define DTC_ADDR_MODE      8'h89
`define DTC_ADDR_LO0       8'h8a
`define DTC_ADDR_LO1       8'h8b
`define DTC_ADDR_HI0       8'h8c
`define DTC_ADDR_HI1       8'h8d
`define DTC_ADDR_RATE      8'h8e

// ----------------------------------------------------------------------
// control and rate select register bit positions
// ----------------------------------------------------------------------
`define DTC_OVF1_BIT       7
`define DTC_RUN1_BIT       6
`define DTC_OVF0_BIT       5
`define DTC_RUN0_BIT       4
`define DTC_XF1_BIT        3
`define DTC_XT1_BIT        2
`define DTC_XF0_BIT        1
`define DTC_XT0_BIT        0
`define DTC_RATE1_BIT      4
`define DTC_RATE0_BIT      3

// ----------------------------------------------------------------------
// reset values and fixed patterns
// ----------------------------------------------------------------------
`define DTC_BYTE_ZERO      8'h00
`define DTC_BYTE_ONES      8'hff
`define DTC_BYTE_ONE       8'h01
`define DTC_RATE_RESET     8'h01
`define DTC_C13_LO_ONES    5'h1f
`define DTC_C13_ONES       13'h1fff
`define DTC_C16_ONES       16'hffff
`define DTC_C13_ONE        13'h0001
`define DTC_C16_ONE        16'h0001

// ----------------------------------------------------------------------
// timer rate prescaler, in cpu clocks per increment
// ----------------------------------------------------------------------
`define DTC_DIV_FAST       4
`define DTC_DIV_SLOW       12
`define DTC_PRE_LAST       4'hb
`define DTC_PRE_FAST_MASK  4'h3
`define DTC_PRE_ONE        4'h1
`define DTC_PRE_ZERO       4'h0

`endif

// [dtc_pkg.sv]
// dtc_pkg.sv - types shared by the dual timer modules
// assumes: dtc_cfg.svh is on the include path
package dtc_pkg;
	`include "dtc_cfg.svh"

	// counting mode of a timer
	typedef enum logic [1:0] {
		DTC_MODE_13BIT  = 2'b00,
		DTC_MODE_16BIT  = 2'b01,
		DTC_MODE_RELOAD = 2'b10,
		DTC_MODE_SPLIT  = 2'b11
	} dtc_mode_t;

	// one timer's nibble of the mode select register
	typedef struct packed {
		logic      gate;
		logic      count_sel;
		dtc_mode_t mode;
	} dtc_tmode_t;

	// result of one counting step
	typedef struct packed {
		logic       ovf;
		logic [7:0] lo;
		logic [7:0] hi;
	} dtc_step_t;

	// synchronised pin bundle
	typedef struct packed {
		logic level;
		logic fall;
	} dtc_pin_t;
endpackage

// [dtc_pin_sync.sv]
// dtc_pin_sync.sv - two-flop synchroniser with falling edge detector
// assumes: pin is asynchronous to clk, held at least two clocks per level
`timescale 1ns/100ps
module dtc_pin_sync
	import dtc_pkg::*;
(
	// clock and reset
	input  wire logic     clk,
	input  wire logic     reset_n,
	// pin and result
	input  wire logic     pin,
	output dtc_pin_t      sync_out
);
	logic meta_reg;
	logic level_reg;
	logic prev_reg;

	// ----------------------------------------------------------------------
	// synchroniser chain, idle level is high
	// ----------------------------------------------------------------------
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			meta_reg  <= 1'b1;
			level_reg <= 1'b1;
			prev_reg  <= 1'b1;
		end
		else
		begin
			meta_reg  <= pin;
			level_reg <= meta_reg;
			prev_reg  <= level_reg;
		end
	end

	// one pulse per falling transition
	assign sync_out.level = level_reg;
	assign sync_out.fall  = prev_reg & ~level_reg;
endmodule

// [dtc_timer_top.sv]
// dtc_timer_top.sv - two timer/counters with external interrupt 0/1 detection
// assumes: cpu core drives the sfr port synchronously to clk and pulses an
// acknowledge when it vectors to each interrupt routine
//
// Summary of operation
// - overflow sets timer flag; vectoring to its routine clears it
// - timer counts only while its run bit is one
// - edge mode: falling edge sets irq1 flag; vector or software clears
// - level mode: irq1 flag follows inverted pin; software writes ignored
// - irq1 type bit: one selects falling edge, zero selects low level
// - irq0 behaves like irq1 with its own flag and type bit
// - mode 0 counter is high byte above low byte bits 0 to 4
// - gate bit set: count only while the interrupt pin is high
// - counter/timer bit picks divided clock or count pin falls
// - mode 0 rolls from all ones, sets flag, pulses output one cycle
// - mode 1 is full 16-bit counter, otherwise like mode 0
// - mode 2 low byte counts, reloads from high byte on overflow
// - timer 0 in mode 3 stops timer 1, which keeps its count
// - mode 3 timer 0 low byte counts with timer 0 controls
// - mode bits: 00 13-bit, 01 16-bit, 10 reload, 11 split
// - mode 3 timer 0 high byte counts clock, uses timer 1 run and flag
// - rate bit one: every four clocks, zero: every twelve clocks
`timescale 1ns/100ps
module dtc_timer_top
	import dtc_pkg::*;
(
	// clock and reset
	input  wire logic        clk,
	input  wire logic        reset_n,
	// special function register port
	input  wire logic [7:0]  sfr_addr,
	input  wire logic        sfr_wr,
	input  wire logic [7:0]  sfr_wdata,
	input  wire logic        sfr_rd,
	output logic      [7:0]  sfr_rdata,
	// interrupt vectoring acknowledges
	input  wire logic        ack_timer0,
	input  wire logic        ack_timer1,
	input  wire logic        ack_irq0,
	input  wire logic        ack_irq1,
	// pins
	input  wire logic        ext_irq0_pin_n,
	input  wire logic        ext_irq1_pin_n,
	input  wire logic        timer0_count_pin,
	input  wire logic        timer1_count_pin,
	output logic             timer0_overflow_out,
	output logic             timer1_overflow_out,
	// flag view for the interrupt controller
	output logic      [7:0]  timer_run_and_int_flags
);
	// ----------------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------------
	logic [7:0] flags_reg;
	logic [7:0] timer_mode_select_reg;
	logic [7:0] timer_rate_select_reg;
	logic [7:0] timer0_low_byte;
	logic [7:0] timer0_high_byte;
	logic [7:0] timer1_low_byte;
	logic [7:0] timer1_high_byte;
	logic [7:0] lo0_next;
	logic [7:0] hi0_next;
	logic [7:0] lo1_next;
	logic [7:0] hi1_next;
	logic [3:0] pre_reg;
	logic       tick_fast;
	logic       tick_slow;
	logic [3:0] pin_raw;
	dtc_pin_t   pin_sync [4];
	dtc_tmode_t tmode0;
	dtc_tmode_t tmode1;
	dtc_step_t  step0;
	dtc_step_t  step1;
	logic       src0;
	logic       src1;
	logic       rate0;
	logic       rate1;
	logic       inc0;
	logic       inc1;
	logic       inc_th0;
	logic       ovf0;
	logic       ovf1;
	logic       ovf_th0;
	logic       wr_flags;

	assign tmode0   = dtc_tmode_t'(timer_mode_select_reg[3:0]);
	assign tmode1   = dtc_tmode_t'(timer_mode_select_reg[7:4]);
	assign wr_flags = sfr_wr && (sfr_addr == `DTC_ADDR_FLAGS);
	assign timer_run_and_int_flags = flags_reg;

	// one counting step of a timer in the given mode
	function automatic dtc_step_t dtc_step(dtc_mode_t mode, logic [7:0] lo,
		logic [7:0] hi);
		dtc_step_t  r;
		logic [12:0] c13;
		logic [15:0] c16;
		r   = '{ovf: 1'b0, lo: lo, hi: hi};
		c13 = {hi, lo[4:0]} + `DTC_C13_ONE;
		c16 = {hi, lo} + `DTC_C16_ONE;
		case (mode)
			DTC_MODE_13BIT:
			begin
				r.ovf = ({hi, lo[4:0]} == `DTC_C13_ONES);
				r.hi  = c13[12:5];
				r.lo  = {lo[7:5], c13[4:0]};
			end
			DTC_MODE_16BIT:
			begin
				r.ovf = ({hi, lo} == `DTC_C16_ONES);
				r.hi  = c16[15:8];
				r.lo  = c16[7:0];
			end
			DTC_MODE_RELOAD:
			begin
				r.ovf = (lo == `DTC_BYTE_ONES);
				r.lo  = r.ovf ? hi : lo + `DTC_BYTE_ONE;
			end
			default:
			begin
				r.ovf = (lo == `DTC_BYTE_ONES);
				r.lo  = lo + `DTC_BYTE_ONE;
			end
		endcase
		return r;
	endfunction

	// ----------------------------------------------------------------------
	// pin synchronisers: irq0, irq1, count pin 0, count pin 1
	// ----------------------------------------------------------------------
	assign pin_raw = {timer1_count_pin, timer0_count_pin, ext_irq1_pin_n,
		ext_irq0_pin_n};

	generate
		for (genvar i = 0; i < 4; i++)
		begin : g_sync
			dtc_pin_sync u_sync
			(
				.clk      (clk),
				.reset_n  (reset_n),
				.pin      (pin_raw[i]),
				.sync_out (pin_sync[i])
			);
		end
	endgenerate

	// ----------------------------------------------------------------------
	// prescaler: divide by four and by twelve enables
	// ----------------------------------------------------------------------
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			pre_reg <= `DTC_PRE_ZERO;
		else if (pre_reg == `DTC_PRE_LAST)
			pre_reg <= `DTC_PRE_ZERO;
		else
			pre_reg <= pre_reg + `DTC_PRE_ONE;
	end

	assign tick_fast = ((pre_reg & `DTC_PRE_FAST_MASK) == `DTC_PRE_FAST_MASK);
	assign tick_slow = (pre_reg == `DTC_PRE_LAST);

	// ----------------------------------------------------------------------
	// count enables
	// ----------------------------------------------------------------------
	always_comb
	begin
		rate0 = timer_rate_select_reg[`DTC_RATE0_BIT] ? tick_fast : tick_slow;
		rate1 = timer_rate_select_reg[`DTC_RATE1_BIT] ? tick_fast : tick_slow;
		src0  = tmode0.count_sel ? pin_sync[2].fall : rate0;
		src1  = tmode1.count_sel ? pin_sync[3].fall : rate1;
		inc0  = flags_reg[`DTC_RUN0_BIT] && src0
			&& (!tmode0.gate || pin_sync[0].level);
		inc1  = flags_reg[`DTC_RUN1_BIT] && src1
			&& (!tmode1.gate || pin_sync[1].level)
			&& (tmode0.mode != DTC_MODE_SPLIT)
			&& (tmode1.mode != DTC_MODE_SPLIT);
		inc_th0 = (tmode0.mode == DTC_MODE_SPLIT)
			&& flags_reg[`DTC_RUN1_BIT] && rate0;
		step0   = dtc_step(tmode0.mode, timer0_low_byte, timer0_high_byte);
		step1   = dtc_step(tmode1.mode, timer1_low_byte, timer1_high_byte);
		ovf0    = inc0 && step0.ovf;
		ovf1    = inc1 && step1.ovf;
		ovf_th0 = inc_th0 && (timer0_high_byte == `DTC_BYTE_ONES);
	end

	// ----------------------------------------------------------------------
	// next counts; a software write wins over an increment
	// ----------------------------------------------------------------------
	always_comb
	begin
		lo0_next = inc0 ? step0.lo : timer0_low_byte;
		hi0_next = timer0_high_byte;
		if (inc0 && (tmode0.mode != DTC_MODE_SPLIT))
			hi0_next = step0.hi;
		else if (inc_th0)
			hi0_next = timer0_high_byte + `DTC_BYTE_ONE;
		lo1_next = inc1 ? step1.lo : timer1_low_byte;
		hi1_next = inc1 ? step1.hi : timer1_high_byte;
		if (sfr_wr)
		begin
			case (sfr_addr)
				`DTC_ADDR_LO0: lo0_next = sfr_wdata;
				`DTC_ADDR_HI0: hi0_next = sfr_wdata;
				`DTC_ADDR_LO1: lo1_next = sfr_wdata;
				`DTC_ADDR_HI1: hi1_next = sfr_wdata;
				default:       lo0_next = lo0_next;
			endcase
		end
	end

	// count registers
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			timer0_low_byte  <= `DTC_BYTE_ZERO;
			timer0_high_byte <= `DTC_BYTE_ZERO;
			timer1_low_byte  <= `DTC_BYTE_ZERO;
			timer1_high_byte <= `DTC_BYTE_ZERO;
		end
		else
		begin
			timer0_low_byte  <= lo0_next;
			timer0_high_byte <= hi0_next;
			timer1_low_byte  <= lo1_next;
			timer1_high_byte <= hi1_next;
		end
	end

	// mode and rate select registers
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			timer_mode_select_reg <= `DTC_BYTE_ZERO;
			timer_rate_select_reg <= `DTC_RATE_RESET;
		end
		else if (sfr_wr && (sfr_addr == `DTC_ADDR_MODE))
			timer_mode_select_reg <= sfr_wdata;
		else if (sfr_wr && (sfr_addr == `DTC_ADDR_RATE))
			timer_rate_select_reg <= sfr_wdata;
	end

	// ----------------------------------------------------------------------
	// control register: run and type bits, flags with set over clear
	// ----------------------------------------------------------------------
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			flags_reg <= `DTC_BYTE_ZERO;
		else
		begin
			if (wr_flags)
			begin
				flags_reg[`DTC_RUN1_BIT] <= sfr_wdata[`DTC_RUN1_BIT];
				flags_reg[`DTC_RUN0_BIT] <= sfr_wdata[`DTC_RUN0_BIT];
				flags_reg[`DTC_XT1_BIT]  <= sfr_wdata[`DTC_XT1_BIT];
				flags_reg[`DTC_XT0_BIT]  <= sfr_wdata[`DTC_XT0_BIT];
			end
			// timer flags
			if (ovf1 || ovf_th0)
				flags_reg[`DTC_OVF1_BIT] <= 1'b1;
			else if (ack_timer1)
				flags_reg[`DTC_OVF1_BIT] <= 1'b0;
			else if (wr_flags)
				flags_reg[`DTC_OVF1_BIT] <= sfr_wdata[`DTC_OVF1_BIT];
			if (ovf0)
				flags_reg[`DTC_OVF0_BIT] <= 1'b1;
			else if (ack_timer0)
				flags_reg[`DTC_OVF0_BIT] <= 1'b0;
			else if (wr_flags)
				flags_reg[`DTC_OVF0_BIT] <= sfr_wdata[`DTC_OVF0_BIT];
			// external interrupt 1
			if (!flags_reg[`DTC_XT1_BIT])
				flags_reg[`DTC_XF1_BIT] <= ~pin_sync[1].level;
			else if (pin_sync[1].fall)
				flags_reg[`DTC_XF1_BIT] <= 1'b1;
			else if (ack_irq1)
				flags_reg[`DTC_XF1_BIT] <= 1'b0;
			else if (wr_flags)
				flags_reg[`DTC_XF1_BIT] <= sfr_wdata[`DTC_XF1_BIT];
			// external interrupt 0
			if (!flags_reg[`DTC_XT0_BIT])
				flags_reg[`DTC_XF0_BIT] <= ~pin_sync[0].level;
			else if (pin_sync[0].fall)
				flags_reg[`DTC_XF0_BIT] <= 1'b1;
			else if (ack_irq0)
				flags_reg[`DTC_XF0_BIT] <= 1'b0;
			else if (wr_flags)
				flags_reg[`DTC_XF0_BIT] <= sfr_wdata[`DTC_XF0_BIT];
		end
	end

	// ----------------------------------------------------------------------
	// overflow output pulses, one clock each
	// ----------------------------------------------------------------------
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			timer0_overflow_out <= 1'b0;
			timer1_overflow_out <= 1'b0;
		end
		else
		begin
			timer0_overflow_out <= ovf0;
			timer1_overflow_out <= ovf1 || ovf_th0;
		end
	end

	// ----------------------------------------------------------------------
	// read data, one clock after the read strobe; unmapped reads zero
	// ----------------------------------------------------------------------
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			sfr_rdata <= `DTC_BYTE_ZERO;
		else if (sfr_rd)
		begin
			case (sfr_addr)
				`DTC_ADDR_FLAGS: sfr_rdata <= flags_reg;
				`DTC_ADDR_MODE:  sfr_rdata <= timer_mode_select_reg;
				`DTC_ADDR_RATE:  sfr_rdata <= timer_rate_select_reg;
				`DTC_ADDR_LO0:   sfr_rdata <= timer0_low_byte;
				`DTC_ADDR_HI0:   sfr_rdata <= timer0_high_byte;
				`DTC_ADDR_LO1:   sfr_rdata <= timer1_low_byte;
				`DTC_ADDR_HI1:   sfr_rdata <= timer1_high_byte;
				default:         sfr_rdata <= `DTC_BYTE_ZERO;
			endcase
		end
	end
endmodule

// [dtc_timer_assertions.sv]
// dtc_timer_assertions.sv - concurrent checks on the dual timer block ports
// assumes: bound into dtc_timer_top; one clock domain, reset_n active low
`timescale 1ns/100ps
module dtc_timer_chk
	import dtc_pkg::*;
(
	// clock and reset
	input  wire logic       clk,
	input  wire logic       reset_n,
	// acknowledges and pins
	input  wire logic       ack_timer0,
	input  wire logic       ext_irq0_pin_n,
	input  wire logic       ext_irq1_pin_n,
	// outputs watched
	input  wire logic       timer0_overflow_out,
	input  wire logic       timer1_overflow_out,
	input  wire logic [7:0] timer_run_and_int_flags
);
	// ------------------------------------------------------------------
	// properties
	// ------------------------------------------------------------------
	wire [7:0] f;

	// short alias for the flag view
	assign f = timer_run_and_int_flags;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);

	AST_OVF0_ONE: assert property (timer0_overflow_out |=> !timer0_overflow_out)
		else $error("timer0 overflow pulse too long");
	AST_OVF1_ONE: assert property (timer1_overflow_out |=> !timer1_overflow_out)
		else $error("timer1 overflow pulse too long");
	AST_OVF0_FLAG: assert property (timer0_overflow_out |-> f[5])
		else $error("timer0 overflow without flag");
	AST_OVF1_FLAG: assert property (timer1_overflow_out |-> f[7])
		else $error("timer1 overflow without flag");
	AST_ACK0_CLR: assert property (ack_timer0 |=> !f[5] || timer0_overflow_out)
		else $error("timer0 flag survived its acknowledge");
	AST_EDGE1_SET: assert property (f[2] && $fell(ext_irq1_pin_n) |-> ##[1:5] f[3])
		else $error("irq1 falling edge did not set its flag");
	AST_LVL1_FOLLOW: assert property ((!f[2] && !ext_irq1_pin_n) [*5] |-> f[3])
		else $error("irq1 level flag does not follow a low pin");
	AST_LVL0_CLEAR: assert property ((!f[0] && ext_irq0_pin_n) [*5] |-> !f[1])
		else $error("irq0 level flag set while pin high");
	AST_RUN0_STOP: assert property ((!f[4]) [*4] |-> !timer0_overflow_out)
		else $error("timer0 overflowed while stopped");
	AST_RUN1_STOP: assert property ((!f[6]) [*4] |-> !timer1_overflow_out)
		else $error("timer1 overflowed while stopped");

	// main scenarios reached
	cover property (timer0_overflow_out);
	cover property (timer1_overflow_out);
	cover property (ack_timer0 && f[5]);
endmodule

bind dtc_timer_top dtc_timer_chk u_dtc_timer_chk (
	.clk                     (clk),
	.reset_n                 (reset_n),
	.ack_timer0              (ack_timer0),
	.ext_irq0_pin_n          (ext_irq0_pin_n),
	.ext_irq1_pin_n          (ext_irq1_pin_n),
	.timer0_overflow_out     (timer0_overflow_out),
	.timer1_overflow_out     (timer1_overflow_out),
	.timer_run_and_int_flags (timer_run_and_int_flags)
);

// [dtc_cpu_model.sv]
// dtc_cpu_model.sv - behavioural cpu core on the sfr port with vectoring acks
// assumes: shares clk with the timer block; tasks are called by the bench
`timescale 1ns/100ps
module dtc_cpu_model
	import dtc_pkg::*;
(
	// clock
	input  wire logic       clk,
	// sfr port
	output logic      [7:0] sfr_addr,
	output logic            sfr_wr,
	output logic      [7:0] sfr_wdata,
	output logic            sfr_rd,
	input  wire logic [7:0] sfr_rdata,
	// acks: timer0, timer1, irq0, irq1
	output logic      [3:0] ack
);
	// idle bus at time zero
	initial
	begin
		sfr_addr = 8'h00;
		sfr_wr = 1'b0;
		sfr_wdata = 8'h00;
		sfr_rd = 1'b0;
		ack = 4'h0;
	end

	// one write; released lines show inverted data so stale values never match
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		sfr_addr <= a;
		sfr_wdata <= d;
		sfr_wr <= 1'b1;
		@(posedge clk);
		sfr_wr <= 1'b0;
		sfr_addr <= ~a;
		sfr_wdata <= ~d;
	endtask

	// one read; data lands one cycle after the strobe edge
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk);
		sfr_addr <= a;
		sfr_rd <= 1'b1;
		@(posedge clk);
		sfr_rd <= 1'b0;
		sfr_addr <= ~a;
		#1;
		d = sfr_rdata;
	endtask

	// low byte read in the 13-bit mode keeps only the counting bits
	task automatic rd_lo13(input logic [7:0] a, output logic [7:0] d);
		rd(a, d);
		d = d & 8'h1f;
	endtask

	// one-cycle vectoring acknowledge
	task automatic vec(input int i);
		@(posedge clk);
		ack[i] <= 1'b1;
		@(posedge clk);
		ack <= 4'h0;
	endtask
endmodule

// [tb.sv]
// tb.sv - self-checking bench for the dual timer and external interrupt block
// assumes: dtc_cfg.svh on the include path; cpu model issues all sfr traffic
`timescale 1ns/100ps
`include "dtc_cfg.svh"
module tb;
	import dtc_pkg::*;
	// ------------------------------------------------------------------
	// signals and instances
	// ------------------------------------------------------------------
	logic       clk;
	logic       reset_n;
	logic [7:0] sfr_addr;
	logic       sfr_wr;
	logic [7:0] sfr_wdata;
	logic       sfr_rd;
	logic [7:0] sfr_rdata;
	logic [3:0] ack;
	logic [1:0] irq_n;
	logic [1:0] cnt_pin;
	logic       ovf0;
	logic       ovf1;
	logic [7:0] flags;
	logic [7:0] v;
	int         n_fail;
	int         comparisons;

	dtc_timer_top u_dtc_timer_top (.clk(clk), .reset_n(reset_n), .sfr_addr(sfr_addr),
		.sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata),
		.ack_timer0(ack[0]), .ack_timer1(ack[1]), .ack_irq0(ack[2]), .ack_irq1(ack[3]),
		.ext_irq0_pin_n(irq_n[0]), .ext_irq1_pin_n(irq_n[1]),
		.timer0_count_pin(cnt_pin[0]), .timer1_count_pin(cnt_pin[1]),
		.timer0_overflow_out(ovf0), .timer1_overflow_out(ovf1),
		.timer_run_and_int_flags(flags));
	dtc_cpu_model u_dtc_cpu_model (.clk(clk), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
		.sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata), .ack(ack));

	// 200 MHz clock
	initial
	begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	// ------------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------------
	task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic close_out();
		$display("comparisons %0d mismatches %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	// bounded wait for an overflow pulse
	task automatic wait_ovf(input int i);
		int k;
		k = 0;
		while (((i == 0) ? ovf0 : ovf1) !== 1'b1 && k < 200)
		begin
			cyc(1);
			k++;
		end
		if (k >= 200)
		begin
			n_fail++;
			close_out();
		end
	endtask

	// count pin pulse, three cycles high then three low, then back high
	task automatic pulse(input int i);
		repeat (3) @(posedge clk);
		cnt_pin[i] <= 1'b0;
		repeat (3) @(posedge clk);
		cnt_pin[i] <= 1'b1;
	endtask

	task automatic pin(input int i, input logic lv);
		@(posedge clk);
		irq_n[i] <= lv;
		cyc(6);
	endtask

	// ------------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------------
	task automatic t_regs();
		u_dtc_cpu_model.rd(`DTC_ADDR_FLAGS, v);
		chk("flags reset", v, 8'h00);
		u_dtc_cpu_model.rd(`DTC_ADDR_MODE, v);
		chk("mode reset", v, 8'h00);
		u_dtc_cpu_model.rd(`DTC_ADDR_RATE, v);
		chk("rate reset", v, 8'h01);
		u_dtc_cpu_model.rd(8'h8f, v);
		chk("unmapped", v, 8'h00);
		$display("done regs");
	endtask

	task automatic t_mode0();
		u_dtc_cpu_model.wr(`DTC_ADDR_MODE, 8'h00);
		u_dtc_cpu_model.wr(`DTC_ADDR_RATE, 8'h01);
		u_dtc_cpu_model.wr(`DTC_ADDR_HI0, 8'hff);
		u_dtc_cpu_model.wr(`DTC_ADDR_LO0, 8'hff);
		u_dtc_cpu_model.wr(`DTC_ADDR_FLAGS, 8'h10);
		wait_ovf(0);
		chk("ovf flag0 set", flags[5], 1'b1);
		cyc(1);
		chk("ovf0 one cycle", ovf0, 1'b0);
		u_dtc_cpu_model.wr(`DTC_ADDR_FLAGS, 8'h20);
		u_dtc_cpu_model.rd(`DTC_ADDR_HI0, v);
		chk("mode0 high", v, 8'h00);
		u_dtc_cpu_model.rd_lo13(`DTC_ADDR_LO0, v);
		chk("mode0 low", v, 8'h00);
		u_dtc_cpu_model.vec(0);
		cyc(2);
		chk("ovf flag0 acked", flags[5], 1'b0);
		$display("done mode0");
	endtask

	// 120 run edges at the selected rate, then check the run bit holds it
	task automatic t_rate(input logic [7:0] ck, input logic [7:0] lo, input logic [7:0] hi);
		logic [7:0] w;
		u_dtc_cpu_model.wr(`DTC_ADDR_MODE, 8'h01);
		u_dtc_cpu_model.wr(`DTC_ADDR_RATE, ck);
		u_dtc_cpu_model.wr(`DTC_ADDR_LO0, 8'h00);
		u_dtc_cpu_model.wr(`DTC_ADDR_HI0, 8'h00);
		u_dtc_cpu_model.wr(`DTC_ADDR_FLAGS, 8'h10);
		repeat (118) @(posedge clk);
		u_dtc_cpu_model.wr(`DTC_ADDR_FLAGS, 8'h00);
		u_dtc_cpu_model.rd(`DTC_ADDR_LO0, v);
		chk("rate count", (v >= lo && v <= hi), 1'b1);
		cyc(30);
		u_dtc_cpu_model.rd(`DTC_ADDR_LO0, w);
		chk("stopped", w, v);
		$display("done rate %h", ck);
	endtask

	task automatic t_reload();
		u_dtc_cpu_model.wr(`DTC_ADDR_MODE, 8'h02);
		u_dtc_cpu_model.wr(`DTC_ADDR_RATE, 8'h01);
		u_dtc_cpu_model.wr(`DTC_ADDR_HI0, 8'hf0);
		u_dtc_cpu_model.wr(`DTC_ADDR_LO0, 8'hfe);
		u_dtc_cpu_model.wr(`DTC_ADDR_FLAGS, 8'h10);
		wait_ovf(0);
		u_dtc_cpu_model.wr(`DTC_ADDR_FLAGS, 8'h00);
		u_dtc_cpu_model.rd(`DTC_ADDR_LO0, v);
		chk("reload low", v, 8'hf0);
		u_dtc_cpu_model.rd(`DTC_ADDR_HI0, v);
		chk("reload high", v, 8'hf0);
		$display("done reload");
	endtask

	task automatic t_gate();
		u_dtc_cpu_model.wr(`DTC_ADDR_MODE, 8'h0d);
		u_dtc_cpu_model.wr(`DTC_ADDR_LO0, 8'h00);
		u_dtc_cpu_model.wr(`DTC_ADDR_FLAGS, 8'h10);
		repeat (3) pulse(0);
		u_dtc_cpu_model.rd(`DTC_ADDR_LO0, v);
		chk("pin count", v, 8'h03);
		pin(0, 1'b0);
		repeat (2) pulse(0);
		u_dtc_cpu_model.rd(`DTC_ADDR_LO0, v);
		chk("gated count", v, 8'h03);
		pin(0, 1'b1);
		u_dtc_cpu_model.wr(`DTC_ADDR_FLAGS, 8'h00);
		$display("done gate");
	endtask

	task automatic t_edge(input int i);
		u_dtc_cpu_model.wr(`DTC_ADDR_FLAGS, 8'h05);
		pin(i, 1'b0);
		chk("edge set", flags[1 + 2 * i], 1'b1);
		chk("other quiet", flags[3 - 2 * i], 1'b0);
		u_dtc_cpu_model.wr(`DTC_ADDR_FLAGS, 8'h05);
		cyc(6);
		chk("sw clear", flags[1 + 2 * i], 1'b0);
		pin(i, 1'b1);
		pin(i, 1'b0);
		chk("edge set again", flags[1 + 2 * i], 1'b1);
		u_dtc_cpu_model.vec(2 + i);
		cyc(2);
		chk("vector clear", flags[1 + 2 * i], 1'b0);
		pin(i, 1'b1);
		$display("done edge %0d", i);
	endtask

	task automatic t_level();
		u_dtc_cpu_model.wr(`DTC_ADDR_FLAGS, 8'h00);
		pin(1, 1'b0);
		chk("level set", flags[3], 1'b1);
		u_dtc_cpu_model.wr(`DTC_ADDR_FLAGS, 8'h00);
		cyc(2);
		chk("write ignored", flags[3], 1'b1);
		pin(1, 1'b1);
		chk("level clear", flags[3], 1'b0);
		$display("done level");
	endtask

	task automatic t_split();
		u_dtc_cpu_model.wr(`DTC_ADDR_MODE, 8'h13);
		u_dtc_cpu_model.wr(`DTC_ADDR_RATE, 8'h19);
		u_dtc_cpu_model.wr(`DTC_ADDR_LO1, 8'h55);
		u_dtc_cpu_model.wr(`DTC_ADDR_HI0, 8'hfe);
		u_dtc_cpu_model.wr(`DTC_ADDR_LO0, 8'h00);
		u_dtc_cpu_model.wr(`DTC_ADDR_FLAGS, 8'h50);
		wait_ovf(1);
		chk("ovf flag1 from high0", flags[7], 1'b1);
		u_dtc_cpu_model.vec(1);
		cyc(2);
		chk("ovf flag1 acked", flags[7], 1'b0);
		u_dtc_cpu_model.wr(`DTC_ADDR_FLAGS, 8'h00);
		u_dtc_cpu_model.rd(`DTC_ADDR_LO1, v);
		chk("timer1 held", v, 8'h55);
		u_dtc_cpu_model.rd(`DTC_ADDR_LO0, v);
		chk("low0 counted", (v != 8'h00), 1'b1);
		$display("done split");
	endtask

	// ------------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------------
	initial
	begin
		n_fail = 0;
		comparisons = 0;
		reset_n = 1'b0;
		irq_n = 2'b11;
		cnt_pin = 2'b11;
		repeat (4) @(posedge clk);
		reset_n <= 1'b1;
		t_regs();
		t_mode0();
		t_rate(8'h01, 8'd9, 8'd11);
		t_rate(8'h09, 8'd29, 8'd31);
		t_reload();
		t_gate();
		t_edge(0);
		t_edge(1);
		t_level();
		t_split();
		close_out();
	end
endmodule
